// *** phy_cond_defines.svh ***
// defines for the condition flag block: offsets, bit positions, resets
// assumes a byte-wide control bus with a 5-bit register address
`ifndef PHY_COND_DEFINES_SVH
`define PHY_COND_DEFINES_SVH

// register offsets on the control bus
`define CFR_ADDR 5'h02
`define CMR_ADDR 5'h03
// read-only registers whose writes are rejected
`define RO_RSR_ADDR 5'h08
`define RO_NCR_ADDR 5'h07
`define RO_NPCR_ADDR 5'h10
`define RO_SCR_ADDR 5'h13
`define RO_SPCR_ADDR 5'h14
`define RO_LECR_ADDR 5'h16
`define RO_IDR_ADDR 5'h18
`define RO_IJCR_ADDR 5'h19

// condition flag bit positions
`define BIT_TXPAR 0
`define BIT_CBPAR 1
`define BIT_REJECT 2
`define BIT_EXT_LO 3
`define NUM_EXT 5
`define BIT_SENSE 7

// reset values
`define CFR_RESET 8'h00
`define CMR_RESET 8'h00
`define RDATA_RESET 8'h00

// parity sense: 1 selects odd parity
`define PAR_ODD 1'b1

`endif

// *** phy_cond_pkg.sv ***
// types shared by the condition flag block
// assumes phy_cond_defines.svh for the numbers
package phy_cond_pkg;

  // all state of the flag block in one record
  typedef struct packed {
    logic [7:0] flags;  // condition flag register
    logic [7:0] mask;   // condition mask register
    logic [7:0] rdata;  // last read data
    logic int_n;        // registered interrupt, active low
  } cond_state_s;

endpackage

// *** parity_check.sv ***
// parity checker for a data word plus its parity line
// assumes data and parity are sampled together on the same edge
`timescale 1ns/1ps
module parity_check #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data, // word under check
  input wire logic parity,           // parity line for the word
  input wire logic odd,              // 1 selects odd parity
  output logic error                 // high when parity is wrong
);

  // xor of all bits plus parity is 1 for a correct odd word
  always_comb begin
    error = ((^data) ^ parity) != odd;
  end

endmodule // parity_check

// *** phy_interrupt_condition_flags.sv ***
// condition flag register, its mask and the active-low interrupt output
// assumes control bus strobes and event inputs are synchronous to ref_clk
`timescale 1ns/1ps
`include "phy_cond_defines.svh"
module phy_interrupt_condition_flags
  import phy_cond_pkg::*;
#(
  parameter int DATA_WIDTH = 8
) (
  input wire logic ref_clk,                        // device clock
  input wire logic reset,                          // async, active high
  input wire logic [4:0] cb_addr,                  // register address
  input wire logic [DATA_WIDTH-1:0] mgmt_bus_data, // write data lines
  input wire logic mgmt_bus_parity,                // write parity line
  input wire logic cb_write,                       // one-cycle write strobe
  input wire logic cb_read,                        // one-cycle read strobe
  output logic [DATA_WIDTH-1:0] cb_rdata,          // read data, registered
  input wire logic tx_request_parity_enable,       // from transmit state reg
  input wire logic tx_word_valid,                  // word enters transmitter
  input wire logic [DATA_WIDTH-1:0] tx_word_data,  // request word
  input wire logic tx_word_parity,                 // request word parity
  input wire logic flag_bit3,                      // event for bit 3
  input wire logic link_error_flag,                // link error event
  input wire logic receive_cond_a_flag,            // receive cond a event
  input wire logic receive_cond_b_flag,            // receive cond b event
  input wire logic user_sense_flag,                // user sense event
  output logic int_n                               // interrupt, active low
);

  cond_state_s st;
  cond_state_s next_st;
  logic tx_perr;
  logic cb_perr;
  logic ro_hit;
  logic good_wr;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [`NUM_EXT-1:0] ext_ev;

  // parity of request words; the source bus does not matter
  parity_check #(.WIDTH(DATA_WIDTH)) u_tx_par (
    .data(tx_word_data),
    .parity(tx_word_parity),
    .odd(`PAR_ODD),
    .error(tx_perr)
  );

  // parity of control bus write data
  parity_check #(.WIDTH(DATA_WIDTH)) u_cb_par (
    .data(mgmt_bus_data),
    .parity(mgmt_bus_parity),
    .odd(`PAR_ODD),
    .error(cb_perr)
  );

  // decode of the read-only registers
  always_comb begin
    unique case (cb_addr)
      `RO_RSR_ADDR,
      `RO_NCR_ADDR,
      `RO_NPCR_ADDR,
      `RO_SCR_ADDR,
      `RO_SPCR_ADDR,
      `RO_LECR_ADDR,
      `RO_IDR_ADDR,
      `RO_IJCR_ADDR: ro_hit = 1'b1;
      default: ro_hit = 1'b0;
    endcase
  end

  // a write with bad parity is discarded
  assign good_wr = cb_write && !cb_perr;

  // external events gathered into the upper flag bits
  assign ext_ev = {user_sense_flag, receive_cond_b_flag,
                   receive_cond_a_flag, link_error_flag, flag_bit3};

  // per-bit set and clear terms
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      if (gi == `BIT_TXPAR) begin : g_tx
        // only words that enter the transmitter are checked
        assign set_vec[gi] = tx_request_parity_enable && tx_word_valid &&
                             tx_perr;
      end else if (gi == `BIT_CBPAR) begin : g_cb
        assign set_vec[gi] = cb_write && cb_perr;
      end else if (gi == `BIT_REJECT) begin : g_rej
        assign set_vec[gi] = cb_write && ro_hit;
      end else begin : g_ext
        assign set_vec[gi] = ext_ev[gi-`BIT_EXT_LO];
      end
      // writing a one clears the flag
      assign clr_vec[gi] = good_wr && (cb_addr == `CFR_ADDR) &&
                           mgmt_bus_data[gi];
    end
  endgenerate

  // next state
  always_comb begin
    next_st = st;
    // sticky flags, set beats clear
    next_st.flags = (st.flags & ~clr_vec) | set_vec;
    if (good_wr && cb_addr == `CMR_ADDR) begin
      next_st.mask = mgmt_bus_data;
    end
    if (cb_read) begin
      unique case (cb_addr)
        `CFR_ADDR: next_st.rdata = st.flags;
        `CMR_ADDR: next_st.rdata = st.mask;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // interrupt while any enabled flag is set
    next_st.int_n = !(|(st.flags & st.mask));
  end

  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st.flags <= `CFR_RESET;
      st.mask <= `CMR_RESET;
      st.rdata <= `RDATA_RESET;
      st.int_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cb_rdata = st.rdata;
  assign int_n = st.int_n;

  // checks on the flag logic
  chk_irq_asserts: assert property (
    @(posedge ref_clk) disable iff (reset)
    (|(st.flags & st.mask)) |=> !int_n)
    else $error("interrupt not driven for enabled flag");

  chk_irq_quiet: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(|(st.flags & st.mask)) |=> int_n)
    else $error("interrupt driven with no enabled flag");

  chk_txpar_sets: assert property (
    @(posedge ref_clk) disable iff (reset)
    tx_request_parity_enable && tx_word_valid && tx_perr
    |=> st.flags[`BIT_TXPAR])
    else $error("request parity flag not set");

  chk_txpar_gated: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(tx_request_parity_enable && tx_word_valid && tx_perr)
    |=> !$rose(st.flags[`BIT_TXPAR]))
    else $error("request parity flag set without cause");

  chk_cbpar_sets: assert property (
    @(posedge ref_clk) disable iff (reset)
    cb_write && cb_perr |=> st.flags[`BIT_CBPAR])
    else $error("control bus parity flag not set");

  chk_reject_sets: assert property (
    @(posedge ref_clk) disable iff (reset)
    cb_write && ro_hit |=> st.flags[`BIT_REJECT])
    else $error("write reject flag not set");

  chk_reject_quiet: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(cb_write && ro_hit) |=> !$rose(st.flags[`BIT_REJECT]))
    else $error("write reject flag set without cause");

  chk_sense_sets: assert property (
    @(posedge ref_clk) disable iff (reset)
    user_sense_flag |=> st.flags[`BIT_SENSE])
    else $error("user sense flag not set");

  chk_flag_sticky: assert property (
    @(posedge ref_clk) disable iff (reset)
    st.flags[`BIT_EXT_LO] && !clr_vec[`BIT_EXT_LO]
    |=> st.flags[`BIT_EXT_LO])
    else $error("flag dropped without a clear");

  chk_set_wins: assert property (
    @(posedge ref_clk) disable iff (reset)
    clr_vec[`BIT_SENSE] && set_vec[`BIT_SENSE]
    |=> st.flags[`BIT_SENSE])
    else $error("clear won over a new event");

  chk_clear_works: assert property (
    @(posedge ref_clk) disable iff (reset)
    clr_vec[`BIT_REJECT] && !set_vec[`BIT_REJECT]
    |=> !st.flags[`BIT_REJECT])
    else $error("flag not cleared by write");

  chk_mask_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    good_wr && cb_addr == `CMR_ADDR |=> st.mask == $past(mgmt_bus_data))
    else $error("mask write lost");

  chk_mask_kept: assert property (
    @(posedge ref_clk) disable iff (reset)
    cb_write && cb_perr |=> st.mask == $past(st.mask))
    else $error("bad parity write changed the mask");

  chk_cbpar_quiet: assert property (
    @(posedge ref_clk) disable iff (reset)
    !(cb_write && cb_perr) |=> !$rose(st.flags[`BIT_CBPAR]))
    else $error("control bus parity flag set without cause");

  chk_bit3_sets: assert property (
    @(posedge ref_clk) disable iff (reset)
    flag_bit3 |=> st.flags[`BIT_EXT_LO])
    else $error("bit 3 event not recorded");

  chk_rdata_flags: assert property (
    @(posedge ref_clk) disable iff (reset)
    cb_read && cb_addr == `CFR_ADDR |=> cb_rdata == $past(st.flags))
    else $error("flag read returned wrong data");

  // main scenarios
  cov_irq: cover property (@(posedge ref_clk) disable iff (reset)
    $fell(int_n));
  cov_txpar: cover property (@(posedge ref_clk) disable iff (reset)
    set_vec[`BIT_TXPAR]);
  cov_reject: cover property (@(posedge ref_clk) disable iff (reset)
    set_vec[`BIT_REJECT] ##[1:8] clr_vec[`BIT_REJECT]);
  cov_collide: cover property (@(posedge ref_clk) disable iff (reset)
    clr_vec[`BIT_SENSE] && set_vec[`BIT_SENSE]);

endmodule // phy_interrupt_condition_flags

// *** mgmt_cpu.sv ***
// management processor model driving the byte-wide control bus
// assumes the bench calls wr and rd; strobes change on falling edges
`timescale 1ns/1ps
module mgmt_cpu (
  input wire logic ref_clk,          // device clock
  output logic [4:0] cb_addr,        // register address
  output logic [7:0] mgmt_bus_data,  // write data
  output logic mgmt_bus_parity,      // write parity, odd
  output logic cb_write,             // write strobe
  output logic cb_read,              // read strobe
  input wire logic [7:0] cb_rdata    // read data
);
  // idle bus at time zero
  initial begin
    cb_addr = 5'h00;
    mgmt_bus_data = 8'h00;
    mgmt_bus_parity = 1'b0;
    cb_write = 1'b0;
    cb_read = 1'b0;
  end
  // one write cycle; bad inverts the odd parity line
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
                    input logic bad);
    @(negedge ref_clk);
    cb_addr = a;
    mgmt_bus_data = d;
    mgmt_bus_parity = ~^d ^ bad;
    cb_write = 1'b1;
    @(negedge ref_clk);
    cb_write = 1'b0;
    mgmt_bus_data = ~d; // released lines do not keep the value
    cb_addr = ~a;
  endtask
  // one read cycle; data is taken once the taking edge has passed
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    cb_addr = a;
    cb_read = 1'b1;
    @(negedge ref_clk);
    cb_read = 1'b0;
    cb_addr = ~a;
    d = cb_rdata;
  endtask
endmodule // mgmt_cpu

// *** phy_interrupt_condition_flags_test.sv ***
// self-checking bench for the condition flag block
// assumes mgmt_cpu for bus cycles; inputs change on falling edges
`timescale 1ns/1ps
module phy_interrupt_condition_flags_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] cb_addr;
  logic [7:0] mgmt_bus_data, cb_rdata, rd, tx_d, expv;
  logic mgmt_bus_parity, cb_write, cb_read, int_n;
  logic tx_en = 1'b0;
  logic tx_v = 1'b0;
  logic tx_p = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [4:0] ro [8] = '{5'h07, 5'h08, 5'h10, 5'h13, 5'h14, 5'h16,
                         5'h18, 5'h19};
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  mgmt_cpu u_mgmt_cpu (.ref_clk(ref_clk), .cb_addr(cb_addr),
    .mgmt_bus_data(mgmt_bus_data), .mgmt_bus_parity(mgmt_bus_parity),
    .cb_write(cb_write), .cb_read(cb_read), .cb_rdata(cb_rdata));
  phy_interrupt_condition_flags u_phy_interrupt_condition_flags (
    .ref_clk(ref_clk), .reset(reset), .cb_addr(cb_addr),
    .mgmt_bus_data(mgmt_bus_data), .mgmt_bus_parity(mgmt_bus_parity),
    .cb_write(cb_write), .cb_read(cb_read), .cb_rdata(cb_rdata),
    .tx_request_parity_enable(tx_en), .tx_word_valid(tx_v),
    .tx_word_data(tx_d), .tx_word_parity(tx_p), .flag_bit3(ev[0]),
    .link_error_flag(ev[1]), .receive_cond_a_flag(ev[2]),
    .receive_cond_b_flag(ev[3]), .user_sense_flag(ev[4]), .int_n(int_n));
  // verdict and end of run
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // byte comparison
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // register read and compare
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    u_mgmt_cpu.rd(a, rd);
    cmp(rd, e);
  endtask
  // one request word offered to the transmitter side
  task automatic txw(input logic en, input logic v, input logic bad);
    @(negedge ref_clk);
    tx_en = en;
    tx_v = v;
    tx_d = 8'h5a;
    tx_p = ~^8'h5a ^ bad;
    @(negedge ref_clk);
    tx_v = 1'b0;
    tx_d = 8'ha5;
  endtask
  // one-cycle event pulse
  task automatic pulse(input int i);
    @(negedge ref_clk);
    ev[i] = 1'b1;
    @(negedge ref_clk);
    ev = 5'h00;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      conclude();
    end
  end
  // main sequence
  initial begin
    tx_d = 8'h00;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    rdc(5'h02, 8'h00);
    rdc(5'h03, 8'h00);
    cmp({7'h00, int_n}, 8'h01);
    u_mgmt_cpu.wr(5'h03, 8'hff, 1'b0);
    rdc(5'h03, 8'hff);
    txw(1'b0, 1'b1, 1'b1);
    txw(1'b1, 1'b0, 1'b1);
    txw(1'b1, 1'b1, 1'b0);
    rdc(5'h02, 8'h00);
    txw(1'b1, 1'b1, 1'b1);
    rdc(5'h02, 8'h01);
    cmp({7'h00, int_n}, 8'h00);
    u_mgmt_cpu.wr(5'h02, 8'h01, 1'b0);
    rdc(5'h02, 8'h00);
    cmp({7'h00, int_n}, 8'h01);
    u_mgmt_cpu.wr(5'h03, 8'h0f, 1'b1);
    rdc(5'h02, 8'h02);
    rdc(5'h03, 8'hff);
    u_mgmt_cpu.wr(5'h02, 8'h02, 1'b0);
    // every read-only place rejects a write
    foreach (ro[i]) begin
      u_mgmt_cpu.wr(ro[i], 8'h00, 1'b0);
      rdc(5'h02, 8'h04);
      u_mgmt_cpu.wr(5'h02, 8'h04, 1'b0);
      rdc(5'h02, 8'h00);
    end
    // the other events accumulate and stay
    expv = 8'h00;
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      expv = expv | (8'h08 << i);
      rdc(5'h02, expv);
    end
    // a new event wins over a clear in the same cycle
    fork
      u_mgmt_cpu.wr(5'h02, 8'hf8, 1'b0);
      pulse(4);
    join
    rdc(5'h02, 8'h80);
    u_mgmt_cpu.wr(5'h03, 8'h7f, 1'b0);
    repeat (2) @(negedge ref_clk);
    cmp({7'h00, int_n}, 8'h01);
    u_mgmt_cpu.wr(5'h03, 8'h80, 1'b0);
    repeat (2) @(negedge ref_clk);
    cmp({7'h00, int_n}, 8'h00);
    // reset in mid-run clears flags, mask and interrupt
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    reset = 1'b0;
    rdc(5'h02, 8'h00);
    rdc(5'h03, 8'h00);
    cmp({7'h00, int_n}, 8'h01);
    conclude();
  end
endmodule // phy_interrupt_condition_flags_test
